//--- hw/param_store.v
// parameter table with working and nonvolatile_store copies
`timescale 1ns/100ps
`include "restore_defs.vh"
module param_store #(
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire          clk_in,
  input  wire          rst_in,
  input  wire          wr_in,
  input  wire [AW-1:0] waddr_in,
  input  wire [31:0]   wdata_in,
  input  wire          nv_wr_in,
  input  wire [AW-1:0] raddr_in,
  output wire [31:0]   rdata_out,
  input  wire          load_in,
  input  wire [AW-1:0] load_addr_in
);
  reg [31:0] work_r [0:DEPTH-1];
  reg [31:0] nonvolatile_store [0:DEPTH-1];
  integer i;
  assign rdata_out = work_r[raddr_in];
  // ======================================
  // storage
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        work_r[i] <= 32'h00000000;
      end
    end else if (load_in) begin
      work_r[load_addr_in] <= nonvolatile_store[load_addr_in];
    end else if (wr_in) begin
      work_r[waddr_in] <= wdata_in;
    end
  end
  always @(posedge clk_in) begin
    if (wr_in && nv_wr_in) begin
      nonvolatile_store[waddr_in] <= wdata_in;
    end
  end
endmodule

//--- hw/restore_cmd_handler.v
// command handler for class 64h explicit messages with restore key decode
// Functional notes
// [R1] a command is taken only with class 100 and attribute zero, the instance picks the command.
// [R2] each value is carried as 8, 16 or 32 bits or as a string per its data type.
// [R3] mode-dependent commands are refused outside their permitted operating modes.
// [R4] storable commands are kept in nonvolatile store and reloaded at power-up.
// [R5] communication-setting commands are writable only through the network channel.
// [R6] the restore key is write only, refuses reads and is never stored.
// [R7] key 165b reloads the Ethernet communication settings.
// [R8] key 1cae reloads the RS232 communication settings.
// [R9] key 7405 reloads non-axis parameters and key 8137 the axis parameters.
// [R10] any other key changes nothing and answers invalid value.
`timescale 1ns/100ps
`include "restore_defs.vh"
module restore_cmd_handler #(
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        req_in,
  input  wire        write_in,
  input  wire        net_chan_in,
  input  wire [7:0]  class_in,
  input  wire [7:0]  attr_in,
  input  wire [15:0] inst_in,
  input  wire [2:0]  len_in,
  input  wire [31:0] wdata_in,
  input  wire [3:0]  op_mode_in,
  output reg         ack_out,
  output reg  [7:0]  status_out,
  output reg  [31:0] rdata_out,
  output reg         busy_out,
  output reg         restore_done_out,
  output reg  [1:0]  restore_group_out
);
  localparam S_BOOT = 2'h0;
  localparam S_IDLE = 2'h1;
  localparam S_LOAD = 2'h2;
  // entry attributes: type, present, readable, writable, storable, mode-dependent, comm setting
  function [7:0] attr_of;
    input [AW-1:0] idx;
    begin
      case (idx[2:0])
        3'h0: attr_of = {`TYPE_U8,  6'b110000};
        3'h1: attr_of = {`TYPE_U16, 6'b111000};
        3'h2: attr_of = {`TYPE_U32, 6'b111100};
        3'h3: attr_of = {`TYPE_U32, 6'b111010};
        3'h4: attr_of = {`TYPE_STR, 6'b110000};
        default: attr_of = {`TYPE_U16, 6'b111000};
      endcase
      // [R5] ethernet and rs232 groups are comm settings
      attr_of[0] = ~idx[AW-1];
    end
  endfunction
  // group that an entry belongs to
  function [1:0] group_of;
    input [AW-1:0] idx;
    begin
      group_of = idx[AW-1:AW-2];
    end
  endfunction
  function [2:0] width_of;
    input [1:0] t;
    begin
      case (t)
        `TYPE_U8:  width_of = 3'h1;
        `TYPE_U16: width_of = 3'h2;
        `TYPE_U32: width_of = 3'h4;
        default:   width_of = 3'h4;
      endcase
    end
  endfunction
  // value cut to the width of its data type
  function [31:0] fit_of;
    input [1:0]  t;
    input [31:0] v;
    begin
      case (t)
        `TYPE_U8:  fit_of = {24'h000000, v[7:0]};
        `TYPE_U16: fit_of = {16'h0000, v[15:0]};
        default:   fit_of = v;
      endcase
    end
  endfunction
  reg  [1:0]    state_r;
  reg  [AW-1:0] ptr_r;
  reg  [1:0]    grp_r;
  reg           all_r;
  reg           wr;
  reg  [31:0]   wval;
  wire [AW-1:0] idx = inst_in[AW-1:0];
  wire [7:0]    at = attr_of(idx);
  wire [1:0]    dtype = at[7:6];
  wire [31:0]   pdata;
  wire [7:0]    ld_at = attr_of(ptr_r);
  // [R4] only storable entries are recalled
  wire          load = ld_at[2] && ((state_r == S_BOOT) ||
                       (state_r == S_LOAD && group_of(ptr_r) == grp_r));
  param_store #(.DEPTH(DEPTH), .AW(AW)) u_store (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .wr_in        (wr),
    .waddr_in     (idx),
    .wdata_in     (wval),
    .nv_wr_in     (at[2]),
    .raddr_in     (idx),
    .rdata_out    (pdata),
    .load_in      (load),
    .load_addr_in (ptr_r)
  );
  // ======================================
  // request decode
  reg [7:0] st;
  reg       key_ok;
  reg [1:0] key_grp;
  always @* begin
    st      = `ST_OK;
    wr      = 1'b0;
    key_ok  = 1'b0;
    key_grp = `GRP_ETHERNET;
    // [R2] width per data type
    wval    = fit_of(dtype, wdata_in);
    // [R1] class and attribute check
    if (class_in != `CMD_CLASS || attr_in != `CMD_ATTR) begin
      st = `ST_BAD_PATH;
    end else if (inst_in == `INST_RESTORE_KEY) begin
      // [R6] write only key
      if (!write_in) begin
        st = `ST_NOT_READABLE;
      end else begin
        case (wdata_in)
          // [R7] ethernet settings
          `KEY_ETHERNET: begin key_ok = 1'b1; key_grp = `GRP_ETHERNET; end
          // [R8] rs232 settings
          `KEY_RS232:    begin key_ok = 1'b1; key_grp = `GRP_RS232; end
          // [R9] non-axis and axis
          `KEY_NON_AXIS: begin key_ok = 1'b1; key_grp = `GRP_NON_AXIS; end
          `KEY_AXIS:     begin key_ok = 1'b1; key_grp = `GRP_AXIS; end
          // [R10] unknown key
          default:       st = `ST_BAD_VALUE;
        endcase
      end
    end else if (inst_in[15:AW] != {(16-AW){1'b0}}) begin
      st = `ST_BAD_PATH;
    end else if (at[1] && op_mode_in[0]) begin
      // [R3] mode-dependent access
      st = `ST_DENIED;
    end else if (write_in) begin
      if (!at[3]) begin
        st = `ST_DENIED;
      end else if (at[0] && !net_chan_in) begin
        // [R5] comm settings by network only
        st = `ST_DENIED;
      end else if (dtype != `TYPE_STR && len_in != width_of(dtype)) begin
        st = `ST_BAD_LEN;
      end else begin
        wr = req_in && state_r == S_IDLE;
      end
    end else if (!at[4]) begin
      st = `ST_NOT_READABLE;
    end
  end
  // ======================================
  // sequencing
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r           <= S_BOOT;
      ptr_r             <= {AW{1'b0}};
      grp_r             <= 2'h0;
      all_r             <= 1'b0;
      ack_out           <= 1'b0;
      status_out        <= 8'h00;
      rdata_out         <= 32'h00000000;
      busy_out          <= 1'b1;
      restore_done_out  <= 1'b0;
      restore_group_out <= 2'h0;
    end else begin
      ack_out          <= 1'b0;
      restore_done_out <= 1'b0;
      all_r            <= 1'b0;
      case (state_r)
        // [R4] power-up recall
        S_BOOT: begin
          ptr_r <= ptr_r + {{(AW-1){1'b0}}, 1'b1};
          if (ptr_r == DEPTH - 1) begin
            state_r  <= S_IDLE;
            busy_out <= 1'b0;
          end
        end
        S_IDLE: begin
          if (req_in) begin
            ack_out    <= 1'b1;
            status_out <= st;
            rdata_out  <= (write_in || st != `ST_OK) ? 32'h00000000 : fit_of(dtype, pdata);
            if (key_ok && st == `ST_OK) begin
              state_r           <= S_LOAD;
              grp_r             <= key_grp;
              ptr_r             <= {AW{1'b0}};
              busy_out          <= 1'b1;
              restore_group_out <= key_grp;
            end
          end
        end
        S_LOAD: begin
          ptr_r <= ptr_r + {{(AW-1){1'b0}}, 1'b1};
          if (ptr_r == DEPTH - 1) begin
            state_r          <= S_IDLE;
            busy_out         <= 1'b0;
            restore_done_out <= 1'b1;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

//--- include/restore_defs.vh
// constants of the parameter restore command handler
`ifndef RESTORE_DEFS_VH
`define RESTORE_DEFS_VH
`define CMD_CLASS          8'h64
`define CMD_ATTR           8'h00
`define INST_RESTORE_KEY   16'h0016
`define KEY_ETHERNET       32'h0000165b
`define KEY_RS232          32'h00001cae
`define KEY_NON_AXIS       32'h00007405
`define KEY_AXIS           32'h00008137
`define GRP_ETHERNET       2'h0
`define GRP_RS232          2'h1
`define GRP_NON_AXIS       2'h2
`define GRP_AXIS           2'h3
`define TYPE_U8            2'h0
`define TYPE_U16           2'h1
`define TYPE_U32           2'h2
`define TYPE_STR           2'h3
`define ST_OK              8'h00
`define ST_BAD_PATH        8'h05
`define ST_DENIED          8'h0f
`define ST_BAD_VALUE       8'h09
`define ST_BAD_LEN         8'h15
`define ST_NOT_READABLE    8'h2c
`endif

//--- tb/net_host.sv
// network controller model issuing explicit messages
`timescale 1ns/100ps
module net_host (
  input  wire        clk_in, busy_out,
  output reg         req_in, write_in, net_chan_in,
  output reg  [7:0]  class_in, attr_in,
  output reg  [15:0] inst_in,
  output reg  [2:0]  len_in,
  output reg  [31:0] wdata_in,
  output reg  [3:0]  op_mode_in
);
  initial begin
    {req_in, write_in, net_chan_in} = 3'h1;
    {class_in, attr_in, inst_in} = 32'h00000000;
    {len_in, wdata_in, op_mode_in} = 39'h0000000000;
  end
  // class, attribute and instance per message
  task xfer(input w, input n, input [7:0] c, input [7:0] a, input [15:0] i, input [2:0] l,
            input [31:0] d, input [3:0] m);
    begin
      @(negedge clk_in);
      while (busy_out)
        @(negedge clk_in);
      @(posedge clk_in);
      req_in <= 1'b1;
      {write_in, net_chan_in, class_in, attr_in, inst_in} <= {w, n, c, a, i};
      {len_in, wdata_in, op_mode_in} <= {l, d, m};
      @(posedge clk_in);
      req_in <= 1'b0;
      wdata_in <= ~d;
      @(negedge clk_in);
    end
  endtask
endmodule

//--- tb/restore_cmd_handler_sva.sv
// checker of the restore command handler
`timescale 1ns/100ps
module restore_cmd_sva (
  input wire        clk_in, rst_in, req_in, write_in, net_chan_in,
  input wire        ack_out, busy_out, restore_done_out,
  input wire [7:0]  class_in, attr_in, status_out,
  input wire [15:0] inst_in,
  input wire [2:0]  len_in,
  input wire [31:0] wdata_in, rdata_out,
  input wire [3:0]  op_mode_in,
  input wire [1:0]  restore_group_out
);
  wire tk = req_in && !busy_out;
  wire ok = tk && class_in == 8'h64 && attr_in == 8'h00;
  wire kw = ok && write_in && len_in == 3'h4 && inst_in == 16'h0016;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_path; tk && (class_in != 8'h64 || attr_in != 8'h00) |=>
    ack_out && status_out == 8'h05; endproperty
  a_path: assert property (p_path) else $error("bad path taken");
  property p_u16; ok && !write_in && inst_in == 16'h1 |=>
    rdata_out[31:16] == 16'h0; endproperty
  a_u16: assert property (p_u16) else $error("u16 read too wide");
  property p_mode; ok && inst_in == 16'h3 && op_mode_in[0] |=>
    status_out == 8'h0f; endproperty
  a_mode: assert property (p_mode) else $error("mode gate open");
  property p_chan; ok && write_in && !net_chan_in && inst_in == 16'h1 |=>
    status_out == 8'h0f; endproperty
  a_chan: assert property (p_chan) else $error("comm write off network");
  property p_rdkey; ok && !write_in && inst_in == 16'h0016 |=>
    status_out == 8'h2c; endproperty
  a_rdkey: assert property (p_rdkey) else $error("key readable");
  property p_eth; kw && wdata_in == 32'h165b |=>
    busy_out && restore_group_out == 2'h0; endproperty
  a_eth: assert property (p_eth) else $error("ethernet restore");
  property p_rs; kw && wdata_in == 32'h1cae |=>
    busy_out && restore_group_out == 2'h1; endproperty
  a_rs: assert property (p_rs) else $error("rs232 restore");
  property p_nax; kw && wdata_in == 32'h7405 |=>
    busy_out && restore_group_out == 2'h2; endproperty
  a_nax: assert property (p_nax) else $error("non-axis restore");
  property p_ax; kw && wdata_in == 32'h8137 |=>
    busy_out && restore_group_out == 2'h3; endproperty
  a_ax: assert property (p_ax) else $error("axis restore");
  property p_bad; kw && wdata_in[31:16] != 16'h0 |=>
    status_out == 8'h09 && !busy_out; endproperty
  a_bad: assert property (p_bad) else $error("bad key taken");
  property p_done; ack_out && busy_out && status_out == 8'h00 |->
    ##32 restore_done_out && !busy_out; endproperty
  a_done: assert property (p_done) else $error("restore length");
  c_key: cover property (kw);
  c_done: cover property (restore_done_out);
  c_deny: cover property (ack_out && status_out == 8'h0f);
endmodule
bind restore_cmd_handler restore_cmd_sva restore_cmd_sva_i (.*);

//--- tb/tb_top.sv
// testbench of the restore command handler
`timescale 1ns/100ps
module tb_top;
  reg clk_in = 1'b0;
  reg rst_in = 1'b1;
  wire req_in, write_in, net_chan_in, ack_out, busy_out, restore_done_out;
  wire [7:0] class_in, attr_in, status_out;
  wire [15:0] inst_in;
  wire [2:0] len_in;
  wire [31:0] wdata_in, rdata_out;
  wire [3:0] op_mode_in;
  wire [1:0] restore_group_out;
  integer failures = 0, cmp_count = 0, g, cyc;
  localparam [127:0] KEYS = {32'h8137, 32'h7405, 32'h1cae, 32'h165b};
  always #5 clk_in = ~clk_in;
  restore_cmd_handler restore_cmd_handler_i (.*);
  net_host net_host_i (.*);
  task chk(input string n, input [40:0] e, input [40:0] s);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("CHECK FAILED %0s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task run(input w, input n, input [15:0] i, input [2:0] l, input [31:0] d, input [3:0] m,
           input [7:0] s, input [31:0] r);
    begin
      net_host_i.xfer(w, n, 8'h64, 8'h00, i, l, d, m);
      chk("answer", {1'b1, s, r}, {ack_out, status_out, rdata_out});
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task t_access;
    begin
      run(1, 1, 16'h1, 3'h2, 32'h1234abcd, 4'h0, 8'h00, 0);
      run(0, 1, 16'h1, 3'h2, 0, 4'h0, 8'h00, 32'habcd);
      run(1, 1, 16'h1, 3'h4, 1, 4'h0, 8'h15, 0);
      run(1, 1, 16'h0, 3'h1, 5, 4'h0, 8'h0f, 0);
      run(1, 0, 16'h11, 3'h2, 32'hffff5a5a, 4'h0, 8'h00, 0);
      run(0, 1, 16'h11, 3'h2, 0, 4'h0, 8'h00, 32'h5a5a);
      run(1, 1, 16'h3, 3'h4, 5, 4'h1, 8'h0f, 0);
      run(0, 1, 16'h3, 3'h4, 0, 4'h1, 8'h0f, 0);
      run(1, 1, 16'h3, 3'h4, 5, 4'h0, 8'h00, 0);
      run(1, 0, 16'h1, 3'h2, 7, 4'h0, 8'h0f, 0);
      run(0, 0, 16'h1, 3'h2, 0, 4'h0, 8'h00, 32'habcd);
      run(0, 1, 16'h40, 3'h2, 0, 4'h0, 8'h05, 0);
      net_host_i.xfer(0, 1, 8'h65, 8'h00, 16'h1, 3'h2, 0, 4'h0);
      chk("path", {1'b1, 8'h05, 32'h0}, {ack_out, status_out, rdata_out});
      net_host_i.xfer(0, 1, 8'h64, 8'h01, 16'h1, 3'h2, 0, 4'h0);
      chk("attr", {1'b1, 8'h05, 32'h0}, {ack_out, status_out, rdata_out});
      $display("access done");
    end
  endtask
  task t_store;
    begin
      run(1, 1, 16'h2, 3'h4, 32'h89abcdef, 4'h0, 8'h00, 0);
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(negedge clk_in);
      chk("boot busy", 2'h2, {busy_out, ack_out});
      run(0, 1, 16'h2, 3'h4, 0, 4'h0, 8'h00, 32'h89abcdef);
      $display("store done");
    end
  endtask
  task t_key;
    begin
      run(0, 1, 16'h16, 3'h4, 0, 4'h0, 8'h2c, 0);
      for (g = 0; g < 4; g = g + 1) begin
        run(1, 1, 16'h16, 3'h4, KEYS[32*g +: 32], 4'h0, 8'h00, 0);
        chk("group", {1'b1, g[1:0]}, {busy_out, restore_group_out});
        cyc = 0;
        while (restore_done_out !== 1'b1 && cyc < 40) begin
          @(negedge clk_in);
          cyc = cyc + 1;
        end
        chk("restore end", {2'h2, 8'h20}, {restore_done_out, busy_out, cyc[7:0]});
      end
      run(1, 1, 16'h16, 3'h4, 32'h0001165b, 4'h0, 8'h09, 0);
      chk("no restore", 2'h0, {busy_out, restore_done_out});
      run(0, 1, 16'h2, 3'h4, 0, 4'h0, 8'h00, 32'h89abcdef);
      $display("key done");
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    t_access;
    t_store;
    t_key;
    end_sim;
  end
  initial begin
    #50000;
    failures = failures + 1;
    end_sim;
  end
endmodule
